// *** tmz_chk.sv ***
// Checker for the timer block: bus handshake, interrupt gating and watchdog tick relations.
// Assumes it is bound to tmz_timer and sees only that module's ports.
module tmz_chk
    import tmz_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic wd_tick_in,
    input wire logic wd_tick_out,
    input wire logic overflow_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Completed writes are mirrored here, since the enable and owner bits are not ports.
    logic wr_done;
    logic intc_sel;
    logic [7:0] opt_r;
    logic en_r;
    assign wr_done = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign intc_sel = (paddr == TMZ_ADDR_INTCTL) || (paddr == TMZ_ADDR_INTCTL_ALT);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            opt_r <= TMZ_RST_OPTION;
            en_r <= 1'b0;
        end else begin
            if (wr_done && paddr == TMZ_ADDR_OPTION) opt_r <= pwdata[7:0];
            if (wr_done && intc_sel) en_r <= pwdata[TMZ_BIT_IRQEN];
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        psel && penable && pready ##1 !pready;
    endsequence
    property p_answer;
        s_access |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer missing or too long");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error response outside answer cycle");
    property p_idle_data;
        !pready |-> prdata == 32'h0;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("read data outside answer cycle");
    property p_byte;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_byte: assert property (p_byte) else $error("upper read data not zero");
    property p_irq_en;
        $rose(overflow_irq) |-> en_r;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("interrupt rose while disabled");
    property p_irq_mask;
        wr_done && intc_sel && !(pwdata[TMZ_BIT_IRQEN] && pwdata[TMZ_BIT_FLAG]) |=> !overflow_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt stayed after mask");
    property p_irq_hold;
        overflow_irq && !psel |=> overflow_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without software");
    property p_wd_plain;
        !psel && !$past(psel) && !opt_r[TMZ_BIT_ASSIGN] |-> wd_tick_out == $past(wd_tick_in);
    endproperty
    a_wd_plain: assert property (p_wd_plain) else $error("watchdog tick scaled without scaler");
endmodule // tmz_chk

bind tmz_timer tmz_chk u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wd_tick_in(wd_tick_in), .wd_tick_out(wd_tick_out), .overflow_irq(overflow_irq));

// *** tmz_pin_src.sv ***
// Pulse source for the external count pin, toggling it a requested number of times.
// Assumes the bench raises start for one cycle and then waits for busy to fall.
module tmz_pin_src #(
    parameter int HALF = 4
) (
    // Clock
    input wire logic mclk,
    // Request
    input wire logic start,
    input wire logic [15:0] toggles,
    // Pin and status
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // The pin idles low; the source always drives it.
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end
    // Each level is held HALF cycles, well above what the synchroniser needs.
    always begin
        @(posedge mclk);
        if (start) begin
            busy <= 1'b1;
            repeat (toggles) begin
                repeat (HALF) @(posedge mclk);
                pin <= ~pin;
            end
            busy <= 1'b0;
        end
    end
endmodule // tmz_pin_src

// *** tmz_pkg.sv ***
// Package for the timer/counter block with shared scaler.
// Assumes a single 100 MHz clock and an APB register bus with 32-bit data.
package tmz_pkg;
    // ****************************************************************
    // Register map (byte addresses, printed offsets are not all word aligned)
    // ****************************************************************
    localparam logic [7:0] TMZ_IDX_TIMER = 8'h01;
    localparam logic [7:0] TMZ_IDX_INTCTL = 8'h0B;
    localparam logic [7:0] TMZ_IDX_INTCTL_ALT = 8'h8B;
    localparam logic [7:0] TMZ_IDX_OPTION = 8'h81;
    localparam logic [7:0] TMZ_IDX_PORTDIR = 8'h85;
    localparam logic [7:0] TMZ_IDX_CTRL = 8'hC0;
    localparam logic [11:0] TMZ_ADDR_TIMER = {2'h0, TMZ_IDX_TIMER, 2'h0};
    localparam logic [11:0] TMZ_ADDR_INTCTL = {2'h0, TMZ_IDX_INTCTL, 2'h0};
    localparam logic [11:0] TMZ_ADDR_INTCTL_ALT = {2'h0, TMZ_IDX_INTCTL_ALT, 2'h0};
    localparam logic [11:0] TMZ_ADDR_OPTION = {2'h0, TMZ_IDX_OPTION, 2'h0};
    localparam logic [11:0] TMZ_ADDR_PORTDIR = {2'h0, TMZ_IDX_PORTDIR, 2'h0};
    localparam logic [11:0] TMZ_ADDR_CTRL = {2'h0, TMZ_IDX_CTRL, 2'h0};

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TMZ_BIT_FLAG = 2;
    localparam int TMZ_BIT_IRQEN = 5;
    localparam int TMZ_BIT_ASSIGN = 3;
    localparam int TMZ_BIT_EDGE = 4;
    localparam int TMZ_BIT_SRC = 5;
    localparam int TMZ_BIT_SLEEP = 0;
    localparam int TMZ_BIT_WDCLR = 1;

    // ****************************************************************
    // Reset values and masks
    // ****************************************************************
    localparam logic [7:0] TMZ_RST_TIMER = 8'h00;
    localparam logic [7:0] TMZ_RST_INTCTL = 8'h00;
    localparam logic [7:0] TMZ_RST_OPTION = 8'hFF;
    localparam logic [4:0] TMZ_RST_PORTDIR = 5'h1F;
    localparam logic [7:0] TMZ_MAX_COUNT = 8'hFF;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int TMZ_CLK_MHZ = 100;
    localparam int TMZ_PHASES = 4;
    localparam logic [1:0] TMZ_Q1 = 2'h0;
    localparam logic [1:0] TMZ_Q2 = 2'h1;
    localparam logic [1:0] TMZ_Q4 = 2'h3;
    localparam logic [1:0] TMZ_INHIBIT_CY = 2'h2;
    localparam logic [2:0] TMZ_IRQ_LAT_CY = 3'h4;
endpackage : tmz_pkg

// *** tmz_ripple.sv ***
// Scaler counter: eight-bit divider with a tap selected by the ratio field.
// Assumes the count enable and clear come from logic on the same clock.
module tmz_ripple
    import tmz_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control
    input wire logic clr,
    input wire logic step,
    input wire logic [2:0] tap_sel,
    input wire logic wd_mode,
    // Result
    output logic tick,
    output logic level
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [8:0] mask;
    logic wd_bypass;

    // A divide-by-2^n tap fires when the low n bits all roll to zero.
    assign cnt_nxt = cnt_r + 8'h01;
    assign mask = wd_mode ? ((9'h001 << tap_sel) - 9'h001) : ((9'h002 << tap_sel) - 9'h001);
    assign wd_bypass = wd_mode && (tap_sel == 3'h0);
    assign tick = step && (wd_bypass || ((cnt_nxt & mask[7:0]) == 8'h00));
    // Tap level of the divider in timer mode, bit 0 in watchdog mode: symmetrical square wave when fed by pin edges.
    assign level = wd_mode ? cnt_r[0] : cnt_r[tap_sel];

    // Counter is cleared by hardware only; software never reads or loads it.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 8'h00;
        end else if (clr) begin
            cnt_r <= 8'h00;
        end else if (step) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // tmz_ripple

// *** tmz_tb.sv ***
// Self-checking bench for the timer block: APB tasks, pin source and watchdog tick driver.
// Assumes tmz_timer, its checker and tmz_pin_src are compiled before it.
module tb import tmz_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic wd_tick_in = 1'b0;
    logic start = 1'b0;
    logic [15:0] toggles = 16'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ext_count_input, wd_tick_out, overflow_irq, busy;
    int err_count = 0;
    int samples_checked = 0;
    int wd_cnt = 0;

    tmz_timer dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_count_input(ext_count_input), .wd_tick_in(wd_tick_in), .wd_tick_out(wd_tick_out),
        .overflow_irq(overflow_irq));
    tmz_pin_src u_src (.mclk(mclk), .start(start), .toggles(toggles), .pin(ext_count_input), .busy(busy));

    // Free-running clock and a count of watchdog ticks seen on wd_tick_out, scaled or raw.
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (wd_tick_out === 1'b1) wd_cnt <= wd_cnt + 1;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic test_done();
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chkb(input string nm, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    // One APB transfer; a fresh edge first so psel is never assigned twice in one step.
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            chkb("pready", 1'b1, pready);
            test_done();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        bus(1'b1, a, d, q, e);
        chkb("write response", 1'b0, e);
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] x);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 8'h00, q, e);
        chk(nm, {24'h0, x}, q);
    endtask
    // Toggle the count pin, then leave time for the synchroniser delay.
    task automatic pulses(input int t);
        int n;
        @(posedge mclk);
        toggles <= t[15:0];
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (busy === 1'b1 && n < 20000);
        if (busy !== 1'b0) begin
            chkb("pin source idle", 1'b0, busy);
            test_done();
        end
        repeat (20) @(posedge mclk);
    endtask
    task automatic ticks(input int p);
        repeat (p) begin
            @(posedge mclk);
            wd_tick_in <= 1'b1;
            @(posedge mclk);
            wd_tick_in <= 1'b0;
        end
        repeat (8) @(posedge mclk);
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        logic [31:0] q;
        logic e;
        logic [7:0] a;
        int c;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        // Reset values, and an unmapped address answered with an error.
        rd("timer reset", TMZ_ADDR_TIMER, 8'h00);
        rd("intctl reset", TMZ_ADDR_INTCTL, 8'h00);
        rd("option reset", TMZ_ADDR_OPTION, 8'hFF);
        rd("portdir reset", TMZ_ADDR_PORTDIR, 8'h1F);
        wr(TMZ_ADDR_PORTDIR, 8'h0A);
        rd("portdir written", TMZ_ADDR_PORTDIR, 8'h0A);
        bus(1'b0, 12'h010, 8'h00, q, e);
        chkb("unmapped error", 1'b1, e);
        // Unscaled pin counting: falling edges from reset, then rising edges with an odd toggle count.
        pulses(6);
        rd("falling edges", TMZ_ADDR_TIMER, 8'h03);
        wr(TMZ_ADDR_OPTION, 8'h28);
        pulses(3);
        rd("rising edges", TMZ_ADDR_TIMER, 8'h05);
        // Scaler on the timer: two full scaled periods of pin edges give exactly two counts.
        // Whole periods keep the result independent of where in a period the tap first rises.
        for (int k = 0; k < 8; k++) begin
            wr(TMZ_ADDR_CTRL, 8'h02);
            wr(TMZ_ADDR_OPTION, 8'h20 | k[7:0]);
            wr(TMZ_ADDR_TIMER, 8'h00);
            pulses(2 << (k + 2));
            rd("scaled count", TMZ_ADDR_TIMER, 8'h02);
            // The watchdog runs unscaled while the timer holds the scaler.
            c = wd_cnt;
            ticks(2);
            chk("raw watchdog ticks", 32'd2, wd_cnt - c);
        end
        // Hand the scaler back to the watchdog through an intermediate ratio.
        wr(TMZ_ADDR_CTRL, 8'h02);
        wr(TMZ_ADDR_TIMER, 8'h00);
        wr(TMZ_ADDR_OPTION, 8'h2F);
        wr(TMZ_ADDR_OPTION, 8'h08);
        // Overflow in timer mode: two inhibited cycles, three counts, then four cycles of latency.
        wr(TMZ_ADDR_INTCTL, 8'h20);
        wr(TMZ_ADDR_TIMER, 8'hFD);
        c = 0;
        while (overflow_irq !== 1'b1 && c < 100) begin
            @(posedge mclk);
            c++;
        end
        chkb("irq latency window", 1'b1, c >= 28 && c <= 44);
        repeat (40) @(posedge mclk);
        rd("flag held", TMZ_ADDR_INTCTL, 8'h24);
        wr(TMZ_ADDR_INTCTL, 8'h04);
        @(posedge mclk);
        chkb("irq masked", 1'b0, overflow_irq);
        rd("flag kept", TMZ_ADDR_INTCTL, 8'h04);
        wr(TMZ_ADDR_INTCTL_ALT, 8'h00);
        rd("flag cleared", TMZ_ADDR_INTCTL, 8'h00);
        // Sleep freezes the count; waking lets it run again.
        wr(TMZ_ADDR_CTRL, 8'h01);
        rd("sleep bit", TMZ_ADDR_CTRL, 8'h01);
        bus(1'b0, TMZ_ADDR_TIMER, 8'h00, q, e);
        a = q[7:0];
        repeat (100) @(posedge mclk);
        rd("frozen count", TMZ_ADDR_TIMER, a);
        wr(TMZ_ADDR_CTRL, 8'h00);
        repeat (100) @(posedge mclk);
        bus(1'b0, TMZ_ADDR_TIMER, 8'h00, q, e);
        chkb("runs after wake", 1'b1, q[7:0] !== a);
        // Watchdog ratios; a watchdog clear first empties the scaler.
        for (int k = 0; k < 4; k++) begin
            wr(TMZ_ADDR_OPTION, 8'h28 | k[7:0]);
            wr(TMZ_ADDR_CTRL, 8'h02);
            c = wd_cnt;
            ticks(3 << k);
            chk("watchdog ticks", 32'd3, wd_cnt - c);
        end
        test_done();
    end
    // Guard against a hang that escapes the bounded waits; 50,000 clocks is well past a clean run.
    initial begin
        #500us;
        chkb("run finished", 1'b1, 1'b0);
        test_done();
    end
endmodule // tb

// *** tmz_timer.sv ***
// Timer/counter with overflow flag and a shared scaler, reached over APB.
// Assumes a 100 MHz mclk, an asynchronous external count pin and a watchdog elsewhere.
//
// Operation
// - Count rolling from FFh to 00h sets the overflow flag.
// - Overflow interrupt request is gated by the enable bit, bit 5.
// - Overflow flag, bit 2, stays set until software clears it.
// - Timer stops counting during sleep, so it never wakes the core.
// - Flag sampled every Q1; interrupt asserts four instruction cycles after setting.
// - External count path is sampled on Q2 and Q4 phases.
// - Without the scaler, the pin feeds the synchroniser directly.
// - With the scaler in counter mode, the pin is synchronised, then divided before Q2/Q4 sampling.
// - Timer increments only after synchroniser delay, not at the pin edge.
// - One eight-bit scaler serves timer or watchdog, the other runs unscaled.
// - Option bits 3:0 select scaler owner and ratio.
// - Any timer write clears the scaler while the timer owns it.
// - Watchdog clear resets the scaler while the watchdog owns it.
// - Scaler count is neither readable nor writable by software.
// - Scaler assignment may change at any time.
// - Watchdog ratio 000 divides by 1, 001 by 2.
// - Source bit clear counts instruction cycles; set counts pin edges.
// - Edge bit clear selects rising edge, set selects falling edge.
// - Timer write inhibits incrementing for the next two instruction cycles.
// - Assignment bit clear gives scaler to timer; set gives it to watchdog.
module tmz_timer
    import tmz_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External count pin
    input wire logic ext_count_input,
    // Watchdog side
    input wire logic wd_tick_in,
    output logic wd_tick_out,
    // Interrupt request to the core
    output logic overflow_irq
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] timer_count_value_r;
    logic [7:0] interrupt_control_r;
    logic [7:0] option_config_r;
    logic [4:0] port_a_direction_r;
    logic [1:0] ctrl_r;
    logic [1:0] phase_r;
    logic [1:0] inhibit_r;
    logic [2:0] irq_lat_r;
    logic irq_pend_r;
    logic [2:0] pin_sync_r;
    logic pin_stable_r;
    logic sync_q2_r;
    logic sync_q4_r;
    logic sync_prev_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic wd_tick_r;
    logic irq_r;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire access = psel && penable && !pready_r;
    wire wr_en = access && pwrite && pstrb[0];
    wire hit_timer = paddr == TMZ_ADDR_TIMER;
    wire hit_intctl = (paddr == TMZ_ADDR_INTCTL) || (paddr == TMZ_ADDR_INTCTL_ALT);
    wire hit_option = paddr == TMZ_ADDR_OPTION;
    wire hit_portdir = paddr == TMZ_ADDR_PORTDIR;
    wire hit_ctrl = paddr == TMZ_ADDR_CTRL;
    wire hit_any = hit_timer || hit_intctl || hit_option || hit_portdir || hit_ctrl;
    wire wr_timer = wr_en && hit_timer;
    wire wr_intctl = wr_en && hit_intctl;
    wire wr_option = wr_en && hit_option;
    wire wr_portdir = wr_en && hit_portdir;
    wire wr_ctrl = wr_en && hit_ctrl;

    // Option fields; the assignment may change on any write.
    wire to_watchdog = option_config_r[TMZ_BIT_ASSIGN];
    wire src_pin = option_config_r[TMZ_BIT_SRC];
    wire edge_fall = option_config_r[TMZ_BIT_EDGE];
    wire [2:0] ratio = option_config_r[2:0];
    wire sleeping = ctrl_r[TMZ_BIT_SLEEP];
    wire wd_clear = wr_ctrl && pwdata[TMZ_BIT_WDCLR];

    // ****************************************************************
    // Phase generator: four mclk periods make one instruction cycle
    // ****************************************************************
    wire q1 = phase_r == TMZ_Q1;
    wire q2 = phase_r == TMZ_Q2;
    wire q4 = phase_r == TMZ_Q4;
    wire cycle_end = q4;

    // ****************************************************************
    // External path: pin synchroniser, scaler, phase sampling
    // ****************************************************************
    // Pin passes three flops; a change counts once the last two agree.
    wire pin_agree = pin_sync_r[1] == pin_sync_r[2];
    wire pin_lvl = edge_fall ? !pin_stable_r : pin_stable_r;
    logic pin_lvl_prev_r;
    wire pin_edge = pin_lvl && !pin_lvl_prev_r;

    // Scaler input: pin edges in counter mode, cycle ends in timer mode, watchdog ticks otherwise.
    wire tmr_src_tick = src_pin ? pin_edge : cycle_end;
    wire sc_step = sleeping ? 1'b0 : (to_watchdog ? wd_tick_in : tmr_src_tick);
    wire sc_clr = to_watchdog ? wd_clear : wr_timer;
    logic sc_tick;
    logic sc_level;

    tmz_ripple u_scaler (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(sc_clr),
        .step(sc_step),
        .tap_sel(ratio),
        .wd_mode(to_watchdog),
        .tick(sc_tick),
        .level(sc_level)
    );

    // Pin path output: scaler tap when the timer owns it, else the edge-selected pin.
    wire ext_path = to_watchdog ? pin_lvl : sc_level;
    // Rising edge of the Q2/Q4-sampled path, seen only after the sampling delay.
    wire ext_inc = src_pin && sync_q4_r && !sync_prev_r;
    wire int_inc = !src_pin && (to_watchdog ? cycle_end : sc_tick);
    wire inc = !sleeping && (inhibit_r == 2'h0) && (ext_inc || int_inc);
    wire overflow = inc && (timer_count_value_r == TMZ_MAX_COUNT);

    // ****************************************************************
    // Read mux
    // ****************************************************************
    wire [7:0] rd_byte = hit_timer ? timer_count_value_r :
                         hit_intctl ? interrupt_control_r :
                         hit_option ? option_config_r :
                         hit_portdir ? {3'h0, port_a_direction_r} :
                         hit_ctrl ? {6'h00, 1'b0, ctrl_r[TMZ_BIT_SLEEP]} : 8'h00;

    // Phase counter.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= TMZ_Q1;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // Pin synchroniser; only the second and third stages are compared.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_sync_r <= 3'h0;
            pin_stable_r <= 1'b0;
            // Edge select resets set, so the selected level idles high over a low pin.
            pin_lvl_prev_r <= 1'b1;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], ext_count_input};
            if (pin_agree) begin
                pin_stable_r <= pin_sync_r[2];
            end
            pin_lvl_prev_r <= pin_lvl;
        end
    end

    // Two-phase sampling of the external path (scaler tap or edge-selected pin): Q2 then Q4.
    // Reset high to match the idle path level; a low reset would fake one count after reset.
    // The previous value follows every clock, so an increment lasts one mclk, not a whole cycle.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync_q2_r <= 1'b1;
            sync_q4_r <= 1'b1;
            sync_prev_r <= 1'b1;
        end else begin
            if (q2) begin
                sync_q2_r <= ext_path;
            end
            if (q4) begin
                sync_q4_r <= sync_q2_r;
            end
            sync_prev_r <= sync_q4_r;
        end
    end

    // Timer register: software write wins and arms a two-cycle inhibit.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            timer_count_value_r <= TMZ_RST_TIMER;
            inhibit_r <= 2'h0;
        end else if (wr_timer) begin
            timer_count_value_r <= pwdata[7:0];
            inhibit_r <= TMZ_INHIBIT_CY;
        end else begin
            if (inc) begin
                timer_count_value_r <= timer_count_value_r + 8'h01;
            end
            if (cycle_end && inhibit_r != 2'h0) begin
                inhibit_r <= inhibit_r - 2'h1;
            end
        end
    end

    // Interrupt control: hardware set of the flag beats a software clear.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_control_r <= TMZ_RST_INTCTL;
        end else begin
            if (wr_intctl) begin
                interrupt_control_r <= pwdata[7:0];
            end
            if (overflow) begin
                interrupt_control_r[TMZ_BIT_FLAG] <= 1'b1;
            end
        end
    end

    // Option, port direction and local control registers.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            option_config_r <= TMZ_RST_OPTION;
            port_a_direction_r <= TMZ_RST_PORTDIR;
            ctrl_r <= 2'h0;
        end else begin
            if (wr_option) begin
                option_config_r <= pwdata[7:0];
            end
            if (wr_portdir) begin
                port_a_direction_r <= pwdata[4:0];
            end
            if (wr_ctrl) begin
                ctrl_r <= {1'b0, pwdata[TMZ_BIT_SLEEP]};
            end
        end
    end

    // Interrupt latency: flag and enable sampled at Q1, request after four cycles.
    wire flag_armed = interrupt_control_r[TMZ_BIT_FLAG] && interrupt_control_r[TMZ_BIT_IRQEN];
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_pend_r <= 1'b0;
            irq_lat_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            if (!flag_armed) begin
                irq_pend_r <= 1'b0;
                irq_lat_r <= 3'h0;
                irq_r <= 1'b0;
            end else if (q1) begin
                irq_pend_r <= 1'b1;
                if (irq_pend_r && irq_lat_r != TMZ_IRQ_LAT_CY) begin
                    irq_lat_r <= irq_lat_r + 3'h1;
                end
                irq_r <= irq_pend_r && (irq_lat_r + 3'h1 >= TMZ_IRQ_LAT_CY);
            end
        end
    end

    // Watchdog tick out: scaled when the watchdog owns the scaler, raw otherwise.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wd_tick_r <= 1'b0;
        end else begin
            wd_tick_r <= to_watchdog ? sc_tick : wd_tick_in;
        end
    end

    // APB answer: one wait state; unmapped addresses return an error.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= access;
            pslverr_r <= access && !hit_any;
            prdata_r <= (access && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign wd_tick_out = wd_tick_r;
    assign overflow_irq = irq_r;
endmodule // tmz_timer
